// ===== ccsr_cfg.svh
// Constants for the CPU core state registers: bit positions, offsets, resets.
`ifndef CCSR_CFG_SVH
`define CCSR_CFG_SVH

// ----------------------------------------------------------------------------
// Status flag bit positions
// ----------------------------------------------------------------------------
`define CCSR_FLAG_GIE 7
`define CCSR_FLAG_BCOPY 6
`define CCSR_FLAG_HALF 5
`define CCSR_FLAG_SIGN 4
`define CCSR_FLAG_OVF 3
`define CCSR_FLAG_NEG 2
`define CCSR_FLAG_ZERO 1
`define CCSR_FLAG_CARRY 0
`define CCSR_STATUS_RESET 8'h00

// ----------------------------------------------------------------------------
// Register file and data space
// ----------------------------------------------------------------------------
`define CCSR_GPR_COUNT 32
`define CCSR_GPR_AW 5
`define CCSR_DS_GPR_LAST 16'h001F
`define CCSR_PTR_X_LOW 5'h1A
`define CCSR_PTR_Y_LOW 5'h1C
`define CCSR_PTR_Z_LOW 5'h1E
`define CCSR_GPR_RESET 8'h00

// ----------------------------------------------------------------------------
// I/O space offsets
// ----------------------------------------------------------------------------
`define CCSR_IO_SP_LOW 6'h3D
`define CCSR_IO_SP_HIGH 6'h3E
`define CCSR_IO_STATUS 6'h3F

// ----------------------------------------------------------------------------
// Stack pointer
// ----------------------------------------------------------------------------
`define CCSR_SP_WIDTH 11
`define CCSR_SP_RESET 11'h000
`define CCSR_SP_BYTE 11'h001
`define CCSR_SP_ADDR 11'h002

// ----------------------------------------------------------------------------
// Interrupt return sequence length in clock cycles
// ----------------------------------------------------------------------------
`define CCSR_IRQ_EXIT_CYCLES 4

`endif

// ===== ccsr_pkg.sv
// Types shared by the CPU core state register modules.
`include "ccsr_cfg.svh"

package ccsr_pkg;

  // --------------------------------------------------------------------------
  // Operation codes from the instruction sequencer
  // --------------------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_GIE_SET = 4'h1,
    OP_GIE_CLEAR = 4'h2,
    OP_BIT_TO_FLAG = 4'h3,
    OP_FLAG_TO_BIT = 4'h4,
    OP_STACK_STORE = 4'h5,
    OP_STACK_LOAD = 4'h6,
    OP_CALL_PUSH = 4'h7,
    OP_IRQ_ENTRY = 4'h8,
    OP_SUB_EXIT = 4'h9,
    OP_IRQ_EXIT = 4'hA
  } ccsr_op_e;

  typedef enum logic [1:0] {
    PTR_DISP = 2'h0,
    PTR_POSTINC = 2'h1,
    PTR_PREDEC = 2'h2
  } ccsr_ptr_mode_e;

  typedef enum logic [4:0] {
    EXIT_IDLE = 5'h01,
    EXIT_C1 = 5'h02,
    EXIT_C2 = 5'h04,
    EXIT_C3 = 5'h08,
    EXIT_C4 = 5'h10
  } ccsr_exit_e;

  // --------------------------------------------------------------------------
  // Module state records
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] status;
    ccsr_exit_e exitState;
    logic exitBusy;
    logic irqTake;
    logic [7:0] opA;
    logic [7:0] opB;
    logic [15:0] opPair;
    logic [7:0] ioRdData;
    logic [7:0] dsRdData;
    logic dsHit;
    logic [15:0] ptrAddr;
  } ccsr_core_s;

  typedef struct packed {
    logic [`CCSR_SP_WIDTH-1:0] sp;
  } ccsr_stack_s;

  typedef struct packed {
    logic [`CCSR_GPR_COUNT-1:0][7:0] gpr;
  } ccsr_gpr_s;

endpackage

// ===== ccsr_stack_ptr.sv
// Stack pointer: I/O byte access and push/pop adjustment.
`timescale 1ns/100ps
`include "ccsr_cfg.svh"

module ccsr_stack_ptr
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ioWrEn,
  input wire logic [5:0] ioAddr,
  input wire logic [7:0] ioWrData,
  input wire logic decByte,
  input wire logic decAddr,
  input wire logic incByte,
  input wire logic incAddr,
  output logic [`CCSR_SP_WIDTH-1:0] sp
);
  import ccsr_pkg::*;

  ccsr_stack_s st_q;
  ccsr_stack_s st_d;

  always_comb
  begin
    st_d = st_q;
    // The stack grows downward.
    if (decByte)
      st_d.sp = st_q.sp - `CCSR_SP_BYTE;
    else if (decAddr)
      st_d.sp = st_q.sp - `CCSR_SP_ADDR;
    else if (incByte)
      st_d.sp = st_q.sp + `CCSR_SP_BYTE;
    else if (incAddr)
      st_d.sp = st_q.sp + `CCSR_SP_ADDR;
    // A software byte load overrides that byte of a stack adjustment in the same cycle; the other byte keeps the adjusted value.
    if (ioWrEn && ioAddr == `CCSR_IO_SP_LOW)
      st_d.sp[7:0] = ioWrData;
    if (ioWrEn && ioAddr == `CCSR_IO_SP_HIGH)
      st_d.sp[`CCSR_SP_WIDTH-1:8] = ioWrData[`CCSR_SP_WIDTH-9:0];
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      st_q.sp <= `CCSR_SP_RESET;
    else
      st_q <= st_d;
  end

  assign sp = st_q.sp;

endmodule // ccsr_stack_ptr

// ===== ccsr_reg_file.sv
// General purpose register file: 32 bytes, 8/16-bit ports.
`timescale 1ns/100ps
`include "ccsr_cfg.svh"

module ccsr_reg_file
(
  input wire logic clk,
  input wire logic rst,
  input wire logic wrEn,
  input wire logic wrWide,
  input wire logic [`CCSR_GPR_AW-1:0] wrAddr,
  input wire logic [15:0] wrData,
  input wire logic bitWrEn,
  input wire logic [`CCSR_GPR_AW-1:0] bitAddr,
  input wire logic [2:0] bitSel,
  input wire logic bitWrVal,
  input wire logic [`CCSR_GPR_AW-1:0] rdAddrA,
  input wire logic [`CCSR_GPR_AW-1:0] rdAddrB,
  input wire logic [`CCSR_GPR_AW-1:0] rdAddrD,
  input wire logic [`CCSR_GPR_AW-1:0] ptrLow,
  output logic [7:0] rdDataA,
  output logic [7:0] rdDataB,
  output logic [15:0] rdDataPair,
  output logic [7:0] rdDataD,
  output logic [15:0] ptrVal,
  output logic bitRdVal
);
  import ccsr_pkg::*;

  ccsr_gpr_s rf_q;
  ccsr_gpr_s rf_d;

  logic [`CCSR_GPR_AW-1:0] evenA;
  assign evenA = {rdAddrA[`CCSR_GPR_AW-1:1], 1'b0};

  // --------------------------------------------------------------------------
  // Write ports
  // --------------------------------------------------------------------------
  // A wide write fills an even/odd pair, low byte at the even address.
  always_comb
  begin
    rf_d = rf_q;
    if (wrEn && wrWide)
    begin
      rf_d.gpr[{wrAddr[`CCSR_GPR_AW-1:1], 1'b0}] = wrData[7:0];
      rf_d.gpr[{wrAddr[`CCSR_GPR_AW-1:1], 1'b1}] = wrData[15:8];
    end
    else if (wrEn)
      rf_d.gpr[wrAddr] = wrData[7:0];
    if (bitWrEn)
      rf_d.gpr[bitAddr][bitSel] = bitWrVal;
  end

  // --------------------------------------------------------------------------
  // Read ports
  // --------------------------------------------------------------------------
  // Operand reads look at the next state so a write in this cycle is
  // forwarded; the pointer and bit reads use the stored value to avoid a
  // loop through the pointer update path.
  assign rdDataA = rf_d.gpr[rdAddrA];
  assign rdDataB = rf_d.gpr[rdAddrB];
  assign rdDataPair = {rf_d.gpr[evenA | 5'h01], rf_d.gpr[evenA]};
  assign rdDataD = rf_d.gpr[rdAddrD];
  assign ptrVal = {rf_q.gpr[ptrLow | 5'h01], rf_q.gpr[ptrLow]};
  assign bitRdVal = rf_q.gpr[bitAddr][bitSel];

  always_ff @(posedge clk)
  begin
    if (rst)
      rf_q.gpr <= '{default: `CCSR_GPR_RESET};
    else
      rf_q <= rf_d;
  end

endmodule // ccsr_reg_file

// ===== ccsr_core_state.sv
// Architectural state of the CPU core: flags, registers, pointers, stack.
`timescale 1ns/100ps
`include "ccsr_cfg.svh"

module ccsr_core_state
(
  input wire logic clk,
  input wire logic rst,
  input wire ccsr_pkg::ccsr_op_e op,
  input wire logic irqReq,
  input wire logic [`CCSR_GPR_AW-1:0] rdAddrA,
  input wire logic [`CCSR_GPR_AW-1:0] rdAddrB,
  input wire logic wrEn,
  input wire logic wrWide,
  input wire logic [`CCSR_GPR_AW-1:0] wrAddr,
  input wire logic [15:0] wrData,
  input wire logic [4:0] aluFlagWe,
  input wire logic [4:0] aluFlags,
  input wire logic [`CCSR_GPR_AW-1:0] bitAddr,
  input wire logic [2:0] bitSel,
  input wire logic ioWrEn,
  input wire logic ioRdEn,
  input wire logic [5:0] ioAddr,
  input wire logic [7:0] ioWrData,
  input wire logic dsWrEn,
  input wire logic dsRdEn,
  input wire logic [15:0] dsAddr,
  input wire logic [7:0] dsWrData,
  input wire logic ptrReq,
  input wire logic [1:0] ptrSel,
  input wire ccsr_pkg::ccsr_ptr_mode_e ptrMode,
  input wire logic [5:0] ptrDisp,
  output logic [7:0] cpuStatusFlags,
  output logic irqTake,
  output logic exitBusy,
  output logic [7:0] operandA,
  output logic [7:0] operandB,
  output logic [15:0] operandPair,
  output logic [7:0] ioRdData,
  output logic [7:0] dsRdData,
  output logic dsHit,
  output logic [15:0] ptrAddr,
  output logic [`CCSR_SP_WIDTH-1:0] stackPtr
);
  import ccsr_pkg::*;

  ccsr_core_s cs_q;
  ccsr_core_s cs_d;

  // --------------------------------------------------------------------------
  // Register file hookup
  // --------------------------------------------------------------------------
  logic rfWrEn;
  logic rfWrWide;
  logic [`CCSR_GPR_AW-1:0] rfWrAddr;
  logic [15:0] rfWrData;
  logic [`CCSR_GPR_AW-1:0] ptrLow;
  logic [7:0] rfRdA;
  logic [7:0] rfRdB;
  logic [15:0] rfRdPair;
  logic [7:0] rfRdD;
  logic [15:0] ptrVal;
  logic bitRdVal;
  logic dsInGpr;
  logic ptrUpdate;
  logic [15:0] ptrNext;
  logic [15:0] ptrEff;
  logic bitWrEn;

  assign dsInGpr = (dsAddr <= `CCSR_DS_GPR_LAST);
  assign bitWrEn = (op == OP_FLAG_TO_BIT);

  // Pointer selection; the unused code falls back to the third pair.
  always_comb
  begin
    case (ptrSel)
      2'h0: ptrLow = `CCSR_PTR_X_LOW;
      2'h1: ptrLow = `CCSR_PTR_Y_LOW;
      default: ptrLow = `CCSR_PTR_Z_LOW;
    endcase
  end

  // --------------------------------------------------------------------------
  // Pointer addressing modes
  // --------------------------------------------------------------------------
  always_comb
  begin
    ptrUpdate = 1'b0;
    ptrNext = ptrVal;
    ptrEff = ptrVal;
    case (ptrMode)
      PTR_DISP:
      begin
        ptrEff = ptrVal + {10'h000, ptrDisp};
      end
      PTR_POSTINC:
      begin
        ptrUpdate = ptrReq;
        ptrNext = ptrVal + 16'h0001;
      end
      PTR_PREDEC:
      begin
        ptrUpdate = ptrReq;
        ptrNext = ptrVal - 16'h0001;
        ptrEff = ptrNext;
      end
      default:
      begin
        ptrUpdate = 1'b0;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // Write arbitration
  // --------------------------------------------------------------------------
  // One word write port: the ALU result has priority, then a data-space
  // store into the register window, then a pointer update. The sequencer
  // never issues two of these in one cycle; the order only fixes a result.
  always_comb
  begin
    rfWrEn = 1'b0;
    rfWrWide = 1'b0;
    rfWrAddr = wrAddr;
    rfWrData = wrData;
    if (wrEn)
    begin
      rfWrEn = 1'b1;
      rfWrWide = wrWide;
    end
    else if (dsWrEn && dsInGpr)
    begin
      rfWrEn = 1'b1;
      rfWrAddr = dsAddr[`CCSR_GPR_AW-1:0];
      rfWrData = {8'h00, dsWrData};
    end
    else if (ptrUpdate)
    begin
      rfWrEn = 1'b1;
      rfWrWide = 1'b1;
      rfWrAddr = ptrLow;
      rfWrData = ptrNext;
    end
  end

  ccsr_reg_file u_reg_file
  (
    .clk(clk),
    .rst(rst),
    .wrEn(rfWrEn),
    .wrWide(rfWrWide),
    .wrAddr(rfWrAddr),
    .wrData(rfWrData),
    .bitWrEn(bitWrEn),
    .bitAddr(bitAddr),
    .bitSel(bitSel),
    .bitWrVal(cs_q.status[`CCSR_FLAG_BCOPY]),
    .rdAddrA(rdAddrA),
    .rdAddrB(rdAddrB),
    .rdAddrD(dsAddr[`CCSR_GPR_AW-1:0]),
    .ptrLow(ptrLow),
    .rdDataA(rfRdA),
    .rdDataB(rfRdB),
    .rdDataPair(rfRdPair),
    .rdDataD(rfRdD),
    .ptrVal(ptrVal),
    .bitRdVal(bitRdVal)
  );

  // --------------------------------------------------------------------------
  // Stack pointer
  // --------------------------------------------------------------------------
  logic popStep;
  assign popStep = (cs_q.exitState == EXIT_C2) ||
                   (cs_q.exitState == EXIT_C3);

  ccsr_stack_ptr u_stack_ptr
  (
    .clk(clk),
    .rst(rst),
    .ioWrEn(ioWrEn),
    .ioAddr(ioAddr),
    .ioWrData(ioWrData),
    .decByte(op == OP_STACK_STORE),
    .decAddr(op == OP_CALL_PUSH || op == OP_IRQ_ENTRY),
    .incByte(op == OP_STACK_LOAD || popStep),
    .incAddr(op == OP_SUB_EXIT),
    .sp(stackPtr)
  );

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb
  begin
    cs_d = cs_q;

    // Operands for the instruction now being fetched are captured at this
    // edge, so they stand ready for a full execute cycle while the next
    // fetch proceeds; writes of this cycle are forwarded.
    cs_d.opA = rfRdA;
    cs_d.opB = rfRdB;
    cs_d.opPair = rfRdPair;

    // Arithmetic flags follow the ALU whenever it reports them.
    if (aluFlagWe[4])
      cs_d.status[`CCSR_FLAG_HALF] = aluFlags[4];
    if (aluFlagWe[3])
      cs_d.status[`CCSR_FLAG_OVF] = aluFlags[3];
    if (aluFlagWe[2])
      cs_d.status[`CCSR_FLAG_NEG] = aluFlags[2];
    if (aluFlagWe[1])
      cs_d.status[`CCSR_FLAG_ZERO] = aluFlags[1];
    if (aluFlagWe[0])
      cs_d.status[`CCSR_FLAG_CARRY] = aluFlags[0];

    if (op == OP_BIT_TO_FLAG)
      cs_d.status[`CCSR_FLAG_BCOPY] = bitRdVal;

    // Software writes every bit but the derived sign flag; nothing is saved or restored around
    // an interrupt, so handlers must do it themselves.
    if (ioWrEn && ioAddr == `CCSR_IO_STATUS)
      cs_d.status = ioWrData;

    if (op == OP_GIE_SET)
      cs_d.status[`CCSR_FLAG_GIE] = 1'b1;
    if (op == OP_GIE_CLEAR)
      cs_d.status[`CCSR_FLAG_GIE] = 1'b0;

    // Interrupt take: one-cycle pulse; a clear in the same cycle blocks it
    // so nothing slips in behind a critical-section entry.
    cs_d.irqTake = irqReq && cs_q.status[`CCSR_FLAG_GIE] &&
                   !cs_q.irqTake && op != OP_GIE_CLEAR &&
                   cs_q.exitState == EXIT_IDLE;
    if (cs_d.irqTake)
      cs_d.status[`CCSR_FLAG_GIE] = 1'b0;

    // Interrupt return sequence; the enable set is placed last so it wins.
    case (cs_q.exitState)
      EXIT_IDLE:
      begin
        if (op == OP_IRQ_EXIT)
          cs_d.exitState = EXIT_C1;
      end
      EXIT_C1:
      begin
        cs_d.exitState = EXIT_C2;
      end
      EXIT_C2:
      begin
        cs_d.exitState = EXIT_C3;
      end
      EXIT_C3:
      begin
        cs_d.exitState = EXIT_C4;
      end
      EXIT_C4:
      begin
        cs_d.exitState = EXIT_IDLE;
        cs_d.status[`CCSR_FLAG_GIE] = 1'b1;
      end
      default:
      begin
        cs_d.exitState = EXIT_IDLE;
      end
    endcase
    cs_d.exitBusy = (cs_d.exitState != EXIT_IDLE);

    // The sign flag is derived, never stored independently.
    cs_d.status[`CCSR_FLAG_SIGN] = cs_d.status[`CCSR_FLAG_NEG] ^
                                   cs_d.status[`CCSR_FLAG_OVF];

    // Registered I/O read; unmapped offsets read zero.
    if (ioRdEn)
    begin
      case (ioAddr)
        `CCSR_IO_SP_LOW: cs_d.ioRdData = stackPtr[7:0];
        `CCSR_IO_SP_HIGH: cs_d.ioRdData =
          {5'h00, stackPtr[`CCSR_SP_WIDTH-1:8]};
        `CCSR_IO_STATUS: cs_d.ioRdData = cs_q.status;
        default: cs_d.ioRdData = 8'h00;
      endcase
    end

    // Data-space reads in the register window return register contents.
    cs_d.dsHit = dsRdEn && dsInGpr;
    if (dsRdEn && dsInGpr)
      cs_d.dsRdData = rfRdD;

    if (ptrReq)
      cs_d.ptrAddr = ptrEff;
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  // Single undivided clock; the sequencer supplies no enable of its own.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cs_q.status <= `CCSR_STATUS_RESET;
      cs_q.exitState <= EXIT_IDLE;
      cs_q.exitBusy <= 1'b0;
      cs_q.irqTake <= 1'b0;
      cs_q.opA <= 8'h00;
      cs_q.opB <= 8'h00;
      cs_q.opPair <= 16'h0000;
      cs_q.ioRdData <= 8'h00;
      cs_q.dsRdData <= 8'h00;
      cs_q.dsHit <= 1'b0;
      cs_q.ptrAddr <= 16'h0000;
    end
    else
      cs_q <= cs_d;
  end

  assign cpuStatusFlags = cs_q.status;
  assign irqTake = cs_q.irqTake;
  assign exitBusy = cs_q.exitBusy;
  assign operandA = cs_q.opA;
  assign operandB = cs_q.opB;
  assign operandPair = cs_q.opPair;
  assign ioRdData = cs_q.ioRdData;
  assign dsRdData = cs_q.dsRdData;
  assign dsHit = cs_q.dsHit;
  assign ptrAddr = cs_q.ptrAddr;

endmodule // ccsr_core_state

// ===== ccsr_alu_model.sv
// Adder model standing in for the ALU beside the core state block.
`timescale 1ns/100ps

module ccsr_alu_model
(
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  output logic [7:0] sum,
  output logic [4:0] flags
);
  logic [8:0] full;
  logic [4:0] nib;
  assign full = {1'h0, a} + {1'h0, b};
  assign nib = {1'h0, a[3:0]} + {1'h0, b[3:0]};
  assign sum = full[7:0];
  // Order matches the core's flag enables: H, V, N, Z, C.
  assign flags[4] = nib[4];
  assign flags[3] = (a[7] == b[7]) && (sum[7] != a[7]);
  assign flags[2] = sum[7];
  assign flags[1] = sum == 8'h00;
  assign flags[0] = full[8];
endmodule // ccsr_alu_model

// ===== ccsr_core_state_asserts.sv
// Concurrent checks on the ports of the core state block.
`timescale 1ns/100ps

module ccsr_core_asserts
(
  input wire logic clk,
  input wire logic rst,
  input wire ccsr_pkg::ccsr_op_e op,
  input wire logic irqReq,
  input wire logic ioWrEn,
  input wire logic ioRdEn,
  input wire logic [5:0] ioAddr,
  input wire logic dsRdEn,
  input wire logic [15:0] dsAddr,
  input wire logic [7:0] cpuStatusFlags,
  input wire logic irqTake,
  input wire logic exitBusy,
  input wire logic [7:0] ioRdData,
  input wire logic dsHit,
  input wire logic [10:0] stackPtr
);
  import ccsr_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_sign;
    cpuStatusFlags[4] == (cpuStatusFlags[2] ^ cpuStatusFlags[3]);
  endproperty
  a_sign: assert property (p_sign)
    else $error("sign flag differs from N xor V");
  property p_noTake;
    !cpuStatusFlags[7] || op == OP_GIE_CLEAR |=> !irqTake;
  endproperty
  a_noTake: assert property (p_noTake)
    else $error("interrupt taken while disabled");
  property p_take;
    irqReq && cpuStatusFlags[7] && !irqTake && op != OP_GIE_CLEAR
      && !exitBusy |=> irqTake && !cpuStatusFlags[7];
  endproperty
  a_take: assert property (p_take)
    else $error("interrupt not taken or enable left set");
  property p_gieSet;
    op == OP_GIE_SET && !irqReq && !ioWrEn |=> cpuStatusFlags[7];
  endproperty
  a_gieSet: assert property (p_gieSet)
    else $error("global enable not set");
  property p_exit;
    op == OP_IRQ_EXIT && !exitBusy |=>
      exitBusy [*4] ##1 (!exitBusy && cpuStatusFlags[7]);
  endproperty
  a_exit: assert property (p_exit)
    else $error("interrupt return not four cycles");
  // The store and push checks skip I/O writes, which may also move the pointer.
  property p_exitSp;
    op == OP_IRQ_EXIT && !exitBusy |=>
      ##4 stackPtr == $past(stackPtr, 4) + 11'h002;
  endproperty
  a_exitSp: assert property (p_exitSp)
    else $error("return did not add two to stack pointer");
  property p_store;
    op == OP_STACK_STORE && !ioWrEn && !exitBusy |=>
      stackPtr == $past(stackPtr) - 11'h001;
  endproperty
  a_store: assert property (p_store)
    else $error("byte store did not subtract one");
  property p_push;
    (op == OP_CALL_PUSH || op == OP_IRQ_ENTRY) && !ioWrEn && !exitBusy
      |=> stackPtr == $past(stackPtr) - 11'h002;
  endproperty
  a_push: assert property (p_push)
    else $error("address push did not subtract two");
  property p_spHigh;
    ioRdEn && ioAddr == 6'h3E |=>
      ioRdData == {5'h00, $past(stackPtr[10:8])};
  endproperty
  a_spHigh: assert property (p_spHigh)
    else $error("stack pointer high byte wrong");
  property p_dsHit;
    !$past(rst) |->
      dsHit == ($past(dsRdEn) && $past(dsAddr) <= 16'h001F);
  endproperty
  a_dsHit: assert property (p_dsHit)
    else $error("data space hit wrong");
  cover property (irqTake);
  cover property (exitBusy ##1 !exitBusy);
  cover property (dsHit);
endmodule // ccsr_core_asserts

bind ccsr_core_state ccsr_core_asserts i_ccsr_core_asserts (.*);

// ===== testbench.sv
// Self-checking testbench for the core state block.
`timescale 1ns/100ps

module testbench;
  import ccsr_pkg::*;
  logic clk = 1'h0;
  logic rst = 1'h1;
  ccsr_op_e op = OP_NONE;
  ccsr_ptr_mode_e ptrMode = PTR_DISP;
  logic irqReq = '0, wrEn = '0, wrWide = '0, ioWrEn = '0, ioRdEn = '0;
  logic dsWrEn = '0, dsRdEn = '0, ptrReq = '0, irqTake, exitBusy, dsHit;
  logic [4:0] rdAddrA = '0, rdAddrB = '0, wrAddr = '0, bitAddr = '0;
  logic [4:0] aluFlagWe = '0, aluFlags, f;
  logic [2:0] bitSel = '0;
  logic [5:0] ioAddr = '0, ptrDisp = '0;
  logic [1:0] ptrSel = '0, pendK = '0;
  logic [7:0] ioWrData = '0, dsWrData = '0, operandA, operandB, ioRdData;
  logic [7:0] dsRdData, cpuStatusFlags, x, y, r, stat, lfsrV;
  logic [15:0] wrData = '0, dsAddr = '0, operandPair, ptrAddr;
  logic [10:0] stackPtr, expSp;
  logic [15:0] expQ [$];
  int errors = 0, comparisons = 0, n;
  ccsr_op_e opTab [5] = '{OP_STACK_STORE, OP_CALL_PUSH, OP_IRQ_ENTRY,
    OP_STACK_LOAD, OP_SUB_EXIT};
  logic [10:0] spTab [5] = '{11'h7FF, 11'h7FE, 11'h7FE, 11'h001, 11'h002};

  ccsr_core_state i_ccsr_core_state (.*);
  ccsr_alu_model i_ccsr_alu_model (.a(operandA), .b(operandB), .sum(),
    .flags(aluFlags));

  initial
    forever #2 clk = ~clk;

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic check(input logic [15:0] got, input logic [15:0] e);
    comparisons++;
    if (got !== e)
    begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, e);
    end
  endtask

  task automatic final_report;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Each request is held over one edge and followed by an idle edge, so no
  // strobe is ever assigned twice in one time step.
  task automatic step;
    @(posedge clk);
    #1;
  endtask

  task automatic io(input logic w, input logic [5:0] a, input logic [7:0] d);
    step();
    ioWrEn = w;
    ioRdEn = !w;
    ioAddr = a;
    ioWrData = d;
    if (!w)
      expQ.push_back({8'h00, d});
    step();
    ioWrEn = 1'h0;
    ioRdEn = 1'h0;
  endtask

  task automatic ds(input logic w, input logic [15:0] a, input logic [7:0] d);
    step();
    dsWrEn = w;
    dsRdEn = !w;
    dsAddr = a;
    dsWrData = d;
    if (!w && a <= 16'h001F)
      expQ.push_back({8'h00, d});
    step();
    dsWrEn = 1'h0;
    dsRdEn = 1'h0;
  endtask

  task automatic regWr(input logic [4:0] a, input logic [15:0] d,
    input logic w, input logic [4:0] fw);
    step();
    wrEn = 1'h1;
    wrWide = w;
    wrAddr = a;
    wrData = d;
    aluFlagWe = fw;
    step();
    wrEn = 1'h0;
    aluFlagWe = 5'h00;
  endtask

  task automatic ptr(input logic [1:0] s, input ccsr_ptr_mode_e m,
    input logic [5:0] d, input logic [15:0] e);
    step();
    ptrReq = 1'h1;
    ptrSel = s;
    ptrMode = m;
    ptrDisp = d;
    expQ.push_back(e);
    step();
    ptrReq = 1'h0;
  endtask

  task automatic doOp(input ccsr_op_e o);
    step();
    op = o;
    step();
    op = OP_NONE;
  endtask

  task automatic checkSp;
    io(1'h0, 6'h3D, expSp[7:0]);
    io(1'h0, 6'h3E, {5'h00, expSp[10:8]});
  endtask

  always @(posedge clk)
    pendK <= ioRdEn ? 2'h1 : dsRdEn ? 2'h2 : ptrReq ? 2'h3 : 2'h0;

  // Reads outside the register file raise no hit and left no note.
  always @(negedge clk)
    if (pendK == 2'h1)
      check({8'h00, ioRdData}, expQ.pop_front());
    else if (pendK == 2'h2 && dsHit === 1'h1)
      check({8'h00, dsRdData}, expQ.pop_front());
    else if (pendK == 2'h3)
      check(ptrAddr, expQ.pop_front());

  initial
  begin
    repeat (4000) @(posedge clk);
    errors++;
    final_report();
  end

  initial
  begin
    repeat (5) @(posedge clk);
    #1;
    rst = 1'h0;
    expSp = 11'h000;
    checkSp();
    io(1'h0, 6'h3F, 8'h00);
    io(1'h1, 6'h3E, 8'hFF);
    io(1'h0, 6'h3E, 8'h07);
    io(1'h1, 6'h3D, 8'h10);
    expSp = 11'h710;
    for (int i = 0; i < 5; i++)
    begin
      doOp(opTab[i]);
      expSp = expSp + spTab[i];
      checkSp();
    end
    io(1'h0, 6'h10, 8'h00);
    $display("stack test done");
    doOp(OP_GIE_SET);
    io(1'h0, 6'h3F, 8'h80);
    step();
    irqReq = 1'h1;
    n = 0;
    while (irqTake !== 1'h1 && n < 20)
    begin
      @(negedge clk);
      n++;
    end
    check({15'h0000, irqTake}, 16'h0001);
    step();
    irqReq = 1'h0;
    doOp(OP_IRQ_ENTRY);
    expSp = expSp - 11'h002;
    io(1'h0, 6'h3F, 8'h00);
    doOp(OP_IRQ_EXIT);
    repeat (3) @(posedge clk);
    io(1'h0, 6'h3F, 8'h80);
    expSp = expSp + 11'h002;
    checkSp();
    step();
    op = OP_GIE_CLEAR;
    irqReq = 1'h1;
    step();
    op = OP_NONE;
    io(1'h0, 6'h3F, 8'h00);
    irqReq = 1'h0;
    $display("interrupt test done");
    io(1'h1, 6'h3F, 8'hFF);
    io(1'h0, 6'h3F, 8'hEF);
    stat = 8'hEF;
    lfsrV = 8'h1D;
    rdAddrA = 5'h02;
    rdAddrB = 5'h03;
    for (int i = 0; i < 6; i++)
    begin
      x = (i == 0) ? 8'h80 : lfsrV;
      lfsrV = lfsr(lfsrV);
      y = (i == 0) ? 8'h80 : lfsrV;
      lfsrV = lfsr(lfsrV);
      r = x + y;
      ds(1'h1, 16'h0002, x);
      ds(1'h1, 16'h0003, y);
      regWr(5'h04, {8'h00, r}, 1'h0, 5'h1F);
      f = aluFlags;
      stat = {stat[7:6], f[4], f[2] ^ f[3], f[3:0]};
      ds(1'h0, 16'h0004, r);
      io(1'h0, 6'h3F, stat);
    end
    $display("alu test done");
    bitAddr = 5'h04;
    bitSel = 3'h7;
    doOp(OP_BIT_TO_FLAG);
    stat[6] = r[7];
    io(1'h0, 6'h3F, stat);
    ds(1'h1, 16'h0005, 8'h00);
    bitAddr = 5'h05;
    bitSel = 3'h3;
    doOp(OP_FLAG_TO_BIT);
    ds(1'h0, 16'h0005, {4'h0, stat[6], 3'h0});
    $display("bit copy test done");
    regWr(5'h1E, 16'h1234, 1'h1, 5'h00);
    rdAddrA = 5'h1F;
    step();
    check(operandPair, 16'h1234);
    ds(1'h0, 16'h001F, 8'h12);
    ptr(2'h2, PTR_PREDEC, 6'h00, 16'h1233);
    ptr(2'h2, PTR_POSTINC, 6'h00, 16'h1233);
    ptr(2'h2, PTR_DISP, 6'h05, 16'h1239);
    ds(1'h0, 16'h001E, 8'h34);
    ptr(2'h0, PTR_DISP, 6'h3F, 16'h003F);
    ptr(2'h1, PTR_DISP, 6'h01, 16'h0001);
    ds(1'h0, 16'h0040, 8'h00);
    step();
    check(16'(expQ.size()), 16'h0000);
    $display("pointer test done");
    final_report();
  end
endmodule // testbench
